// ===== pkg/rsfr_pkg.sv
// Constants, carriers and states of the setpoint and fault register block
package rsfr_pkg;

	// Command codes of the serial-bus registers
	localparam logic [7:0] CMD_FWD_SETPOINT = 8'h15;
	localparam logic [7:0] CMD_CFG_A = 8'h39;
	localparam logic [7:0] CMD_CFG_B = 8'h3C;
	localparam logic [7:0] CMD_CFG_C = 8'h3D;
	localparam logic [7:0] CMD_CFG_D = 8'h4C;
	localparam logic [7:0] CMD_CFG_E = 8'h4E;
	localparam logic [7:0] CMD_FAULT_INFO = 8'h3A;

	// Default 7-bit bus address of the device
	localparam logic [6:0] DEV_ADDR_DEFAULT = 7'h09;

	// Setpoint layout: bits 14..3 kept, 12 mV per LSB at bit 3
	localparam logic [15:0] SETPOINT_MASK = 16'h7FF8;
	localparam logic [15:0] SETPOINT_MAX = 16'h36B0;
	localparam logic [15:0] SETPOINT_RESET = 16'h0D08;

	// Configuration reset values
	localparam logic [15:0] CFG_A_RESET = 16'h0000;
	localparam logic [15:0] CFG_B_RESET = 16'h0000;
	localparam logic [15:0] CFG_C_RESET = 16'h0000;
	localparam logic [15:0] CFG_D_RESET = 16'h0000;
	localparam logic [7:0] CFG_E_RESET = 8'h00;

	// Field positions
	localparam int CFG_B_CL_ALERT_OFF = 6;
	localparam int CFG_C_DEB_LSB = 9;
	localparam int CFG_E_ALERT_CLR = 1;
	localparam int INFO_LSB = 7;
	localparam int INFO_MSB = 12;

	// Alert debounce step
	localparam int CLK_FREQ_MHZ = 10;
	localparam int DEBOUNCE_STEP_US = 10;
	localparam int DEBOUNCE_STEP_CYC = DEBOUNCE_STEP_US * CLK_FREQ_MHZ;

	// First configuration register layout
	typedef struct packed {
		logic [2:0] fwd_buck_ofs;
		logic [2:0] boost_ofs;
		logic [2:0] rev_buck_ofs;
		logic [1:0] hs_short_thr;
		logic lv_shdn_en;
		logic lv_shdn_thr;
		logic vin_loop_dis;
		logic adp_dischg_en;
		logic sys_dischg_en;
	} rsfr_cfg_a_type;

	// Fault condition levels, in status bit order 12 down to 8
	typedef struct packed {
		logic severe_overcurrent_fault;
		logic output_overvoltage_fault;
		logic output_undervoltage_fault;
		logic over_temp_fault;
		logic adapter_overvoltage_fault;
	} rsfr_fault_type;

	// Serial engine states
	typedef enum logic [2:0] {
		ST_IDLE = 3'b000,
		ST_RX = 3'b001,
		ST_RX_ACK = 3'b010,
		ST_TX = 3'b011,
		ST_TX_ACK = 3'b100
	} rsfr_state_type;

endpackage

// ===== design/rsfr_regs.sv
// Serial-bus setpoint, configuration and fault alert registers
`timescale 1ns/100ps
module rsfr_regs
	import rsfr_pkg::*;
#(
	parameter logic [6:0] DEV_ADDR = rsfr_pkg::DEV_ADDR_DEFAULT,
	parameter logic [15:0] DEBOUNCE_STEP = 16'(rsfr_pkg::DEBOUNCE_STEP_CYC)
) (
	input wire logic clk, // 10 MHz clock
	input wire logic rst_n, // Synchronous reset, low
	input wire logic scl_in, // Bus clock level
	input wire logic sda_in, // Bus data level
	output logic sda_out, // Data drive level, always low
	output logic sda_oe_n, // Low while pulling data low
	input wire rsfr_pkg::rsfr_fault_type fault_in, // Fault levels
	input wire logic cur_limit_active, // Output current limit mode
	output logic alert_out, // Alert drive level, always low
	output logic alert_oe_n, // Low while alert is pulled low
	output logic [15:0] fwd_output_voltage_setpoint, // Setpoint code
	output rsfr_pkg::rsfr_cfg_a_type config_reg_a, // First config
	output logic [15:0] config_reg_b, // Second config
	output logic [15:0] config_reg_c, // Third config
	output logic [15:0] config_reg_d, // Fourth config
	output logic [15:0] fault_info_status // Latched fault bits
);
	import rsfr_pkg::*;

	// Setpoint filter: mask, zero rejection and clamp
	// binary code kept
	function automatic logic [15:0] sp_filter(input logic [15:0] wr,
		input logic [15:0] old);
		logic [15:0] m;
		m = wr & SETPOINT_MASK;
		if (m == 16'h0000) begin
			sp_filter = old;
		end else if (m > SETPOINT_MAX) begin
			sp_filter = SETPOINT_MAX;
		end else begin
			sp_filter = m;
		end
	endfunction

	rsfr_state_type state_reg, state_next;
	logic scl_q_reg, scl_q_next, sda_q_reg, sda_q_next;
	logic [2:0] bit_cnt_reg, bit_cnt_next;
	logic [2:0] idx_reg, idx_next;
	logic [7:0] sh_reg, sh_next;
	logic [7:0] cmd_reg, cmd_next;
	logic [7:0] lo_reg, lo_next;
	logic rw_reg, rw_next, full_reg, full_next, hi_reg, hi_next;
	logic ack_reg, ack_next;
	logic oe_n_reg, oe_n_next;
	logic [15:0] sp_reg, sp_next;
	logic [15:0] cfg_a_reg, cfg_a_next;
	logic [15:0] cfg_b_reg, cfg_b_next;
	logic [15:0] cfg_c_reg, cfg_c_next;
	logic [15:0] cfg_d_reg, cfg_d_next;
	logic [7:0] cfg_e_reg, cfg_e_next;
	logic alert_clr;
	logic [5:0] info_reg, info_next;
	logic pend_cl_reg, pend_cl_next, cl_q_reg, cl_q_next;
	logic [15:0] deb_reg, deb_next;
	logic alert_oe_n_reg, alert_oe_n_next;
	logic start_c, stop_c, rise_c, fall_c;
	logic [15:0] rd_word;

	// Bus condition detection
	assign start_c = scl_in & scl_q_reg & sda_q_reg & ~sda_in;
	assign stop_c = scl_in & scl_q_reg & ~sda_q_reg & sda_in;
	assign rise_c = scl_in & ~scl_q_reg;
	assign fall_c = ~scl_in & scl_q_reg;

	// Read multiplexer
	// stored value read
	always_comb begin
		unique case (cmd_reg)
			CMD_FWD_SETPOINT: rd_word = sp_reg;
			CMD_CFG_A: rd_word = cfg_a_reg;
			CMD_CFG_B: rd_word = cfg_b_reg;
			CMD_CFG_C: rd_word = cfg_c_reg;
			CMD_CFG_D: rd_word = cfg_d_reg;
			CMD_CFG_E: rd_word = {8'h00, cfg_e_reg};
			CMD_FAULT_INFO: rd_word = fault_info_status;
			default: rd_word = 16'h0000;
		endcase
	end

	// Serial engine and register writes
	always_comb begin
		state_next = state_reg;
		scl_q_next = scl_in;
		sda_q_next = sda_in;
		bit_cnt_next = bit_cnt_reg;
		idx_next = idx_reg;
		sh_next = sh_reg;
		cmd_next = cmd_reg;
		lo_next = lo_reg;
		rw_next = rw_reg;
		full_next = full_reg;
		hi_next = hi_reg;
		ack_next = ack_reg;
		oe_n_next = oe_n_reg;
		sp_next = sp_reg;
		cfg_a_next = cfg_a_reg;
		cfg_b_next = cfg_b_reg;
		cfg_c_next = cfg_c_reg;
		cfg_d_next = cfg_d_reg;
		cfg_e_next = cfg_e_reg;
		alert_clr = 1'b0;
		if (start_c) begin
			state_next = ST_RX;
			bit_cnt_next = 3'h0;
			idx_next = 3'h0;
			full_next = 1'b0;
			oe_n_next = 1'b1;
		end else if (stop_c) begin
			state_next = ST_IDLE;
			oe_n_next = 1'b1;
		end else begin
			unique case (state_reg)
				ST_IDLE: begin
					oe_n_next = 1'b1;
				end
				ST_RX: begin
					if (rise_c) begin
						sh_next = {sh_reg[6:0], sda_in};
						bit_cnt_next = bit_cnt_reg + 3'h1;
						full_next = (bit_cnt_reg == 3'h7);
					end else if (fall_c && full_reg) begin
						full_next = 1'b0;
						bit_cnt_next = 3'h0;
						oe_n_next = 1'b0;
						state_next = ST_RX_ACK;
						unique case (idx_reg)
							3'h0: begin
								rw_next = sh_reg[0];
								if (sh_reg[7:1] != DEV_ADDR) begin
									oe_n_next = 1'b1;
									state_next = ST_IDLE;
								end
							end
							3'h1: cmd_next = sh_reg;
							3'h2: begin
								lo_next = sh_reg;
								if (cmd_reg == CMD_CFG_E) begin
									alert_clr = sh_reg[CFG_E_ALERT_CLR];
									cfg_e_next = sh_reg &
										~(8'h01 << CFG_E_ALERT_CLR);
								end
							end
							3'h3: begin
								unique case (cmd_reg)
									CMD_FWD_SETPOINT:
										sp_next = sp_filter({sh_reg, lo_reg},
											sp_reg);
									CMD_CFG_A: cfg_a_next = {sh_reg, lo_reg};
									CMD_CFG_B: cfg_b_next = {sh_reg, lo_reg};
									CMD_CFG_C: cfg_c_next = {sh_reg, lo_reg};
									CMD_CFG_D: cfg_d_next = {sh_reg, lo_reg};
									default: ;
								endcase
							end
							default: begin
								oe_n_next = 1'b1;
								state_next = ST_IDLE;
							end
						endcase
					end
				end
				ST_RX_ACK: begin
					if (fall_c) begin
						idx_next = idx_reg + 3'h1;
						if (rw_reg && idx_reg == 3'h0) begin
							sh_next = rd_word[7:0];
							oe_n_next = rd_word[7];
							hi_next = 1'b0;
							state_next = ST_TX;
						end else begin
							oe_n_next = 1'b1;
							state_next = ST_RX;
						end
					end
				end
				ST_TX: begin
					if (fall_c) begin
						bit_cnt_next = bit_cnt_reg + 3'h1;
						if (bit_cnt_reg == 3'h7) begin
							oe_n_next = 1'b1;
							state_next = ST_TX_ACK;
						end else begin
							sh_next = {sh_reg[6:0], 1'b0};
							oe_n_next = sh_reg[6];
						end
					end
				end
				ST_TX_ACK: begin
					if (rise_c) begin
						ack_next = ~sda_in;
					end else if (fall_c) begin
						bit_cnt_next = 3'h0;
						if (ack_reg) begin
							sh_next = hi_reg ? 8'h00 : rd_word[15:8];
							oe_n_next = hi_reg ? 1'b0 : rd_word[15];
							hi_next = 1'b1;
							state_next = ST_TX;
						end else begin
							state_next = ST_IDLE;
						end
					end
				end
			endcase
		end
	end

	always_ff @(posedge clk) begin
		if (!rst_n) begin
			state_reg <= ST_IDLE;
			scl_q_reg <= 1'b1;
			sda_q_reg <= 1'b1;
			bit_cnt_reg <= 3'h0;
			idx_reg <= 3'h0;
			sh_reg <= 8'h00;
			cmd_reg <= 8'h00;
			lo_reg <= 8'h00;
			rw_reg <= 1'b0;
			full_reg <= 1'b0;
			hi_reg <= 1'b0;
			ack_reg <= 1'b0;
			oe_n_reg <= 1'b1;
			sp_reg <= SETPOINT_RESET;
			cfg_a_reg <= CFG_A_RESET;
			cfg_b_reg <= CFG_B_RESET;
			cfg_c_reg <= CFG_C_RESET;
			cfg_d_reg <= CFG_D_RESET;
			cfg_e_reg <= CFG_E_RESET;
		end else begin
			state_reg <= state_next;
			scl_q_reg <= scl_q_next;
			sda_q_reg <= sda_q_next;
			bit_cnt_reg <= bit_cnt_next;
			idx_reg <= idx_next;
			sh_reg <= sh_next;
			cmd_reg <= cmd_next;
			lo_reg <= lo_next;
			rw_reg <= rw_next;
			full_reg <= full_next;
			hi_reg <= hi_next;
			ack_reg <= ack_next;
			oe_n_reg <= oe_n_next;
			sp_reg <= sp_next;
			cfg_a_reg <= cfg_a_next;
			cfg_b_reg <= cfg_b_next;
			cfg_c_reg <= cfg_c_next;
			cfg_d_reg <= cfg_d_next;
			cfg_e_reg <= cfg_e_next;
		end
	end

	// Fault debounce, status latch and alert
	always_comb begin
		logic [5:0] active;
		logic cl_evt;
		logic [15:0] dly;
		active = 6'h00;
		cl_evt = 1'b0;
		dly = 16'h0000;
		cl_q_next = cur_limit_active;
		cl_evt = (cur_limit_active ^ cl_q_reg) &
			~cfg_b_reg[CFG_B_CL_ALERT_OFF];
		pend_cl_next = pend_cl_reg | cl_evt;
		active = {fault_in, pend_cl_next};
		dly = 16'(cfg_c_reg[CFG_C_DEB_LSB +: 2] * DEBOUNCE_STEP);
		deb_next = 16'h0000;
		info_next = alert_clr ? 6'h00 : info_reg;
		if (active != 6'h00) begin
			if (deb_reg >= dly) begin
				info_next = info_next | active;
				pend_cl_next = 1'b0;
			end else begin
				deb_next = deb_reg + 16'h0001;
			end
		end
		alert_oe_n_next = ~(|info_next);
	end

	always_ff @(posedge clk) begin
		if (!rst_n) begin
			info_reg <= 6'h00;
			pend_cl_reg <= 1'b0;
			cl_q_reg <= 1'b0;
			deb_reg <= 16'h0000;
			alert_oe_n_reg <= 1'b1;
		end else begin
			info_reg <= info_next;
			pend_cl_reg <= pend_cl_next;
			cl_q_reg <= cl_q_next;
			deb_reg <= deb_next;
			alert_oe_n_reg <= alert_oe_n_next;
		end
	end

	// Outputs straight from flip-flops, drive levels tied low
	assign sda_out = 1'b0;
	assign alert_out = 1'b0;
	assign sda_oe_n = oe_n_reg;
	assign alert_oe_n = alert_oe_n_reg;
	assign fwd_output_voltage_setpoint = sp_reg;
	assign config_reg_a = rsfr_cfg_a_type'(cfg_a_reg);
	assign config_reg_b = cfg_b_reg;
	assign config_reg_c = cfg_c_reg;
	assign config_reg_d = cfg_d_reg;
	assign fault_info_status = {3'b000, info_reg, 7'b000_0000};
endmodule

// ===== sim/rsfr_regs_chk.sv
// Assertion checker bound to the setpoint and fault register block
`timescale 1ns/100ps
module rsfr_regs_chk
	import rsfr_pkg::*;
#(
	parameter logic [6:0] DEV_ADDR = DEV_ADDR_DEFAULT,
	parameter logic [15:0] DEBOUNCE_STEP = 16'h0064
) (
	input wire logic clk, // Clock
	input wire logic rst_n, // Reset, low
	input wire logic scl_in, // Bus clock
	input wire logic sda_in, // Bus data
	input wire logic sda_out, // Data drive
	input wire logic sda_oe_n, // Data enable
	input wire rsfr_pkg::rsfr_fault_type fault_in, // Faults
	input wire logic cur_limit_active, // Current limit
	input wire logic alert_out, // Alert drive
	input wire logic alert_oe_n, // Alert enable
	input wire logic [15:0] fwd_output_voltage_setpoint, // Setpoint
	input wire rsfr_pkg::rsfr_cfg_a_type config_reg_a, // Config A
	input wire logic [15:0] config_reg_b, // Config B
	input wire logic [15:0] config_reg_c, // Config C
	input wire logic [15:0] config_reg_d, // Config D
	input wire logic [15:0] fault_info_status // Fault status
);
	default clocking cb @(posedge clk);
	endclocking
	default disable iff (!rst_n);
	// A fault appearing with no debounce set, then held
	sequence s_fault_rise;
		$rose(|fault_in) && config_reg_c[10:9] == 2'b00;
	endsequence
	sequence s_fault_held;
		(|fault_in) [*3];
	endsequence
	chk_reset_values: assert property (
		disable iff (1'b0) !rst_n |=> fwd_output_voltage_setpoint ==
		SETPOINT_RESET && config_reg_a == 16'h0000 && config_reg_b == 16'h0000
		&& config_reg_c == 16'h0000 && config_reg_d == 16'h0000 &&
		fault_info_status == 16'h0000 && alert_oe_n)
		else $error("register defaults wrong after reset");
	chk_setpoint_mask: assert property (
		(fwd_output_voltage_setpoint & 16'h8007) == 16'h0000)
		else $error("setpoint holds bits outside its field");
	chk_debounce_zero: assert property (
		s_fault_rise ##1 s_fault_held |-> fault_info_status[12:8] != 5'h00
		##[0:2] !alert_oe_n) else $error("fault not latched without debounce");
	chk_cl_alert: assert property (
		$changed(cur_limit_active) && !config_reg_b[6] &&
		config_reg_c[10:9] == 2'b00 |-> ##[1:5] (fault_info_status[7] &&
		!alert_oe_n)) else $error("current limit change gave no alert");
	chk_cl_masked: assert property (
		$changed(cur_limit_active) && config_reg_b[6] && alert_oe_n &&
		fault_in == 5'h00 |=> alert_oe_n [*4])
		else $error("masked current limit change raised alert");
	chk_alert_cause: assert property (
		$fell(alert_oe_n) |-> fault_info_status[12:7] != 6'h00)
		else $error("alert raised with no status bit");
	chk_clear_release: assert property (
		$past(fault_info_status[12:7]) != 6'h00 &&
		fault_info_status[12:7] == 6'h00 |=> alert_oe_n)
		else $error("alert kept after status clear");
	chk_alert_latched: assert property (
		$rose(alert_oe_n) |-> fault_info_status[12:7] == 6'h00 &&
		$past(fault_info_status[12:7]) != 6'h00)
		else $error("alert released with status set");
	// latch outlives the fault while the bus clock is high
	chk_alert_hold: assert property (
		$fell(|fault_in) && !alert_oe_n && scl_in |=> !alert_oe_n)
		else $error("alert dropped when the fault went away");
endmodule

bind rsfr_regs rsfr_regs_chk #(.DEV_ADDR(DEV_ADDR),
	.DEBOUNCE_STEP(DEBOUNCE_STEP)) i_rsfr_regs_chk (.clk(clk), .rst_n(rst_n),
	.scl_in(scl_in), .sda_in(sda_in), .sda_out(sda_out),
	.sda_oe_n(sda_oe_n), .fault_in(fault_in),
	.cur_limit_active(cur_limit_active), .alert_out(alert_out),
	.alert_oe_n(alert_oe_n),
	.fwd_output_voltage_setpoint(fwd_output_voltage_setpoint),
	.config_reg_a(config_reg_a), .config_reg_b(config_reg_b),
	.config_reg_c(config_reg_c), .config_reg_d(config_reg_d),
	.fault_info_status(fault_info_status));

// ===== sim/rsfr_host.sv
// Serial-bus host model that talks to the register block
`timescale 1ns/100ps
module rsfr_host
	import rsfr_pkg::*;
(
	input wire logic clk, // Clock
	input wire logic sda_in, // Wired data level
	output logic scl_out, // Bus clock drive
	output logic sda_oe_n // Low while pulling data low
);
	int phase = 2; // Clocks per bus clock phase, two at least
	initial begin
		scl_out = 1'b1;
		sda_oe_n = 1'b1;
	end
	// Start (1,0) or stop (0,1): data moves while the bus clock is high
	task automatic cond(input logic a, input logic b);
		sda_oe_n <= a;
		repeat (phase) @(posedge clk);
		scl_out <= 1'b1;
		repeat (phase) @(posedge clk);
		sda_oe_n <= b;
		repeat (phase) @(posedge clk);
		scl_out <= b;
		@(posedge clk);
	endtask
	// One bit: set while clock low, sampled at the end of clock high
	task automatic bit_io(input logic b, output logic r);
		sda_oe_n <= b;
		repeat (phase) @(posedge clk);
		scl_out <= 1'b1;
		repeat (phase) @(posedge clk);
		r = sda_in;
		scl_out <= 1'b0;
		@(posedge clk);
	endtask
	// One byte, most significant bit first, then the acknowledge slot
	task automatic xfer(input logic [7:0] d, input logic last,
		output logic [7:0] q, output logic ack);
		logic r;
		for (int i = 7; i >= 0; i--) begin
			bit_io(d[i], q[i]);
		end
		bit_io(last, r);
		ack = ~r;
	endtask
	task automatic write(input logic [7:0] cmd, input logic [15:0] d,
		input int n, output logic ok);
		logic [7:0] q;
		logic [3:0] a;
		cond(1'b1, 1'b0);
		xfer({DEV_ADDR_DEFAULT, 1'b0}, 1'b1, q, a[0]);
		xfer(cmd, 1'b1, q, a[1]);
		xfer(d[7:0], 1'b1, q, a[2]);
		a[3] = 1'b1;
		if (n == 2) begin
			xfer(d[15:8], 1'b1, q, a[3]);
		end
		cond(1'b0, 1'b1);
		ok = &a;
	endtask
	// read word: low byte acked, high byte not
	task automatic read(input logic [7:0] cmd, output logic [15:0] d);
		logic a;
		cond(1'b1, 1'b0);
		xfer({DEV_ADDR_DEFAULT, 1'b0}, 1'b1, d[7:0], a);
		xfer(cmd, 1'b1, d[7:0], a);
		cond(1'b1, 1'b0);
		xfer({DEV_ADDR_DEFAULT, 1'b1}, 1'b1, d[7:0], a);
		xfer(8'hff, 1'b0, d[7:0], a);
		xfer(8'hff, 1'b1, d[15:8], a);
		cond(1'b0, 1'b1);
	endtask
endmodule

// ===== sim/rsfr_regs_tb_top.sv
// Self-checking bench for the setpoint and fault register block
`timescale 1ns/100ps
module rsfr_regs_tb_top;
	import rsfr_pkg::*;
	localparam logic [15:0] MAX = 16'((21000 / 12) << 3); // 21 V code
	logic clk = 1'b0;
	logic rst_n = 1'b0;
	logic cur_lim = 1'b0;
	logic scl, sda, host_oe_n, sda_oe_n, alert_oe_n, ok;
	logic sda_drv, alert_drv;
	rsfr_fault_type fault = 5'h00;
	rsfr_cfg_a_type cfg_a;
	logic [15:0] setp, cfg_b, cfg_c, cfg_d, status, rd, m, exp;
	logic [15:0] sp [6] = '{16'h1234, 16'h8007, 16'h36b8, 16'h36b0,
		16'h0008, 16'hffff};
	int miscompares = 0;
	int samples_checked = 0;
	// Clock and wired-and data line with pull-up
	always #50 clk = ~clk;
	assign sda = host_oe_n & (sda_oe_n | sda_drv);
	rsfr_host i_rsfr_host (.clk(clk), .sda_in(sda), .scl_out(scl),
		.sda_oe_n(host_oe_n));
	rsfr_regs #(.DEBOUNCE_STEP(16'h0004)) i_rsfr_regs (.clk(clk),
		.rst_n(rst_n), .scl_in(scl), .sda_in(sda), .sda_out(sda_drv),
		.sda_oe_n(sda_oe_n), .fault_in(fault), .cur_limit_active(cur_lim),
		.alert_out(alert_drv), .alert_oe_n(alert_oe_n),
		.fwd_output_voltage_setpoint(setp), .config_reg_a(cfg_a),
		.config_reg_b(cfg_b), .config_reg_c(cfg_c), .config_reg_d(cfg_d),
		.fault_info_status(status));
	// Compare one value
	task automatic check(input logic [15:0] got, input logic [15:0] want);
		samples_checked++;
		if (got !== want) begin
			miscompares++;
			$display("ERROR %0t got %h expected %h", $time, got, want);
		end
	endtask
	// Bus write that must be acknowledged, and bus read compare
	task automatic wr(input logic [7:0] cmd, input logic [15:0] d, int n);
		i_rsfr_host.write(cmd, d, n, ok);
		check(16'(ok), 16'h0001);
	endtask
	task automatic rdchk(input logic [7:0] cmd, input logic [15:0] want);
		i_rsfr_host.read(cmd, rd);
		check(rd, want);
	endtask
	// Bounded wait for the alert pin
	task automatic wait_alert;
		for (int n = 0; n < 40 && alert_oe_n !== 1'b0; n++) begin
			@(posedge clk);
		end
		check(16'(alert_oe_n), 16'h0000);
	endtask
	// Report counts and verdict, then end the run
	task automatic stop_test;
		$display("checked %0d mismatched %0d", samples_checked, miscompares);
		if (miscompares == 0 && samples_checked > 0) begin
			$display("TB: PASS");
		end else begin
			$display("TB: FAIL");
		end
		$finish;
	endtask
	// Cut a hang short: the tests need about 0.8 milliseconds
	initial begin
		#3ms;
		miscompares++;
		stop_test();
	end
	// Main sequence
	initial begin
		repeat (8) @(posedge clk);
		rst_n <= 1'b1;
		repeat (2) @(posedge clk);
		exp = 16'((5004 / 12) << 3);
		check(setp, exp);
		check(status, 16'h0000);
		check(16'({sda_drv, alert_drv}), 16'h0000);
		rdchk(CMD_FWD_SETPOINT, exp);
		foreach (sp[i]) begin
			wr(CMD_FWD_SETPOINT, sp[i], 2);
			m = sp[i] & 16'h7ff8;
			exp = (m == 16'h0000) ? exp : ((m > MAX) ? MAX : m);
			check(setp, exp);
			rdchk(CMD_FWD_SETPOINT, exp);
		end
		i_rsfr_host.phase = 6;
		wr(CMD_CFG_A, 16'hb5a6, 2);
		i_rsfr_host.phase = 2;
		check(cfg_a, 16'hb5a6);
		rdchk(CMD_CFG_A, 16'hb5a6);
		wr(CMD_CFG_D, 16'h5a5a, 2);
		check(cfg_d, 16'h5a5a);
		wr(CMD_CFG_E, 16'h0010, 1);
		rdchk(CMD_CFG_E, 16'h0010);
		rdchk(8'h00, 16'h0000);
		wr(CMD_CFG_C, 16'h0200, 2);
		check(cfg_c, 16'h0200);
		for (int i = 0; i < 5; i++) begin
			fault[4 - i] <= 1'b1;
			repeat (3) @(posedge clk);
			check(status, 16'h0000);
			wait_alert();
			check(status, 16'h1000 >> i);
			fault <= 5'h00;
			rdchk(CMD_FAULT_INFO, 16'h1000 >> i);
			wr(CMD_CFG_E, 16'h0002, 1);
			check(status, 16'h0000);
			check(16'(alert_oe_n), 16'h0001);
		end
		cur_lim <= 1'b1;
		wait_alert();
		check(status, 16'h0080);
		wr(CMD_CFG_E, 16'h0002, 1);
		wr(CMD_CFG_B, 16'h0040, 2);
		cur_lim <= 1'b0;
		repeat (20) @(posedge clk);
		check(16'(alert_oe_n), 16'h0001);
		check(status, 16'h0000);
		rdchk(CMD_CFG_B, 16'h0040);
		check(cfg_b, 16'h0040);
		// Zero debounce: fault and limit change latch at once
		wr(CMD_CFG_C, 16'h0000, 2);
		wr(CMD_CFG_B, 16'h0000, 2);
		fault[0] <= 1'b1;
		repeat (2) @(posedge clk);
		check(status, 16'h0100);
		repeat (4) @(posedge clk);
		fault <= 5'h00;
		repeat (4) @(posedge clk);
		check(16'(alert_oe_n), 16'h0000);
		wr(CMD_CFG_E, 16'h0002, 1);
		cur_lim <= 1'b1;
		repeat (3) @(posedge clk);
		check(status, 16'h0080);
		check(16'(alert_oe_n), 16'h0000);
		stop_test();
	end
endmodule
